// ---- pkg/fbo_pkg.sv ----
// Purpose: constants and types for the parallel flash bus-cycle controller
// Assumes: 10 MHz clock, one cycle per 100 ns
// Notes:   cycle counts derive from times in ns and the clock period
package fbo_pkg;

	// -------------------------------------------------------------------
	// clock and timing
	// -------------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS  = 100;
	localparam int ACCESS_TIME_NS   = 120;   // slowest grade access time
	localparam int WRITE_PULSE_NS   = 50;    // least write strobe low time
	localparam int RECOVERY_NS      = 100;   // least idle time between cycles
	localparam int RESET_PULSE_NS   = 500;   // least reset low time
	localparam int RESET_HIGH_NS    = 50;    // wait after reset release

	// round least times up, never below one cycle
	function automatic int fbo_cycles(input int t_ns);
		int c;
		c = (t_ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int ACCESS_CYC   = fbo_cycles(ACCESS_TIME_NS);
	localparam int WRITE_CYC    = fbo_cycles(WRITE_PULSE_NS);
	localparam int RECOVERY_CYC = fbo_cycles(RECOVERY_NS);
	localparam int RESET_CYC    = fbo_cycles(RESET_PULSE_NS);
	localparam int RESET_H_CYC  = fbo_cycles(RESET_HIGH_NS);
	localparam int CNT_W        = 4;

	// -------------------------------------------------------------------
	// address layout and protection pins
	// -------------------------------------------------------------------
	localparam int ADDR_W       = 19;        // word address bits 18..0
	localparam int DATA_W       = 16;
	localparam int BIT_A6       = 6;
	localparam int BIT_A1       = 1;
	localparam int BIT_A0       = 0;
	localparam int BANK_MSB     = 18;
	localparam int BANK_LSB     = 15;
	localparam logic [3:0] TOP_BOOT_BANK = 4'hF;  // boot bank at high end
	localparam logic [3:0] BOT_BOOT_BANK = 4'h0;  // boot bank at low end

	// -------------------------------------------------------------------
	// host request kinds
	// -------------------------------------------------------------------
	typedef enum logic [2:0] {
		FBO_REQ_READ      = 3'h0,
		FBO_REQ_WRITE     = 3'h1,
		FBO_REQ_PROTECT   = 3'h2,
		FBO_REQ_UNPROTECT = 3'h3,
		FBO_REQ_RESET     = 3'h4
	} fbo_req_t;

	// controller states, gray along idle->setup->strobe->recover
	typedef enum logic [2:0] {
		FBO_IDLE    = 3'h0,
		FBO_SETUP   = 3'h1,
		FBO_STROBE  = 3'h3,
		FBO_RECOVER = 3'h2,
		FBO_RST_LOW = 3'h6,
		FBO_RST_WT  = 3'h7
	} fbo_state_t;

endpackage

// ---- core/fbo_timer.sv ----
// Purpose: down counter for bus phase lengths
// Assumes: load and tick never needed in the same cycle by the caller
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
module fbo_timer
	import fbo_pkg::*;
(
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// control
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] load_value,
	// status
	output logic                  done
);

	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;

	// load has priority over counting down
	always_comb begin
		next_count = count;
		if (load) begin
			next_count = load_value;
		end else if (count != '0) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign done = (count == '0);

endmodule

// ---- core/fbo_host.sv ----
// Purpose: host side driver of an asynchronous parallel flash bus
// Assumes: pin inputs synchronous to clock; one request at a time
// Notes:   high voltage on the reset pin is a separate select output
`timescale 1ns/1ps

// Function
// - read: select and gate low, strobe high
// - write: strobe and select low, gate high
// - address 18..0 or 18..-1 in bytes
module fbo_host
	import fbo_pkg::*;
#(
	parameter logic TOP_BOOT = 1'b1
)
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// user request
	input  wire logic              req_valid,
	input  wire fbo_req_t          req_kind,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic              req_low_byte,
	input  wire logic [DATA_W-1:0] req_wdata,
	input  wire logic              byte_mode,
	input  wire logic              temp_unprotect,
	output logic                   req_ready,
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_rdata,
	output logic                   rsp_boot_bank,
	// flash pins
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [DATA_W-1:0]      flash_dq_out,
	output logic [DATA_W-1:0]      flash_dq_oe,
	input  wire logic [DATA_W-1:0] flash_dq_in,
	output logic                   flash_ce_n,
	output logic                   flash_oe_n,
	output logic                   flash_we_n,
	output logic                   flash_reset_n,
	output logic                   flash_high_voltage_level,
	output logic                   flash_word_mode
);

	// -------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------
	// bank decode: boot bank at the top or bottom of the array
	function automatic logic fbo_is_boot(input logic [ADDR_W-1:0] a);
		logic [3:0] b;
		b = a[BANK_MSB:BANK_LSB];
		return TOP_BOOT ? (b == TOP_BOOT_BANK)
		                : (b == BOT_BOOT_BANK);
	endfunction

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	fbo_state_t        state, next_state;
	fbo_req_t          kind, next_kind;
	logic [ADDR_W-1:0] addr_q, next_addr_q;
	logic [DATA_W-1:0] dq_out_q, next_dq_out_q;
	logic [DATA_W-1:0] dq_oe_q, next_dq_oe_q;
	logic              ce_n, next_ce_n;
	logic              oe_n, next_oe_n;
	logic              we_n, next_we_n;
	logic              rst_pin_n, next_rst_pin_n;
	logic              hv, next_hv;
	logic              word_q, next_word_q;
	logic              ready_q, next_ready_q;
	logic              rvalid_q, next_rvalid_q;
	logic [DATA_W-1:0] rdata_q, next_rdata_q;
	logic              boot_q, next_boot_q;
	logic              tmr_load;
	logic [CNT_W-1:0]  tmr_value;
	logic              tmr_done;

	fbo_timer u_timer (
		.clock      (clock),
		.rst_n      (rst_n),
		.load       (tmr_load),
		.load_value (tmr_value),
		.done       (tmr_done)
	);

	// -------------------------------------------------------------------
	// next-state logic
	// -------------------------------------------------------------------
	always_comb begin
		next_state     = state;
		next_kind      = kind;
		next_addr_q    = addr_q;
		next_dq_out_q  = dq_out_q;
		next_dq_oe_q   = dq_oe_q;
		next_ce_n      = ce_n;
		next_oe_n      = oe_n;
		next_we_n      = we_n;
		next_rst_pin_n = rst_pin_n;
		next_hv        = hv;
		next_word_q    = word_q;
		next_ready_q   = ready_q;
		next_rvalid_q  = 1'b0;
		next_rdata_q   = rdata_q;
		next_boot_q    = boot_q;
		tmr_load       = 1'b0;
		tmr_value      = '0;
		unique case (state)
			FBO_IDLE: begin
				// temporary unprotect holds high voltage between cycles
				next_hv = temp_unprotect;
				// let the device out of reset on the first idle edge
				if (!rst_pin_n) begin
					next_rst_pin_n = 1'b1;
				end
				if (req_valid && ready_q) begin
					next_ready_q = 1'b0;
					next_kind    = req_kind;
					next_word_q  = !byte_mode;
					next_addr_q  = req_addr;
					next_boot_q  = fbo_is_boot(req_addr);
					// byte mode: pin 15 carries the low address bit
					next_dq_out_q = req_wdata;
					next_dq_oe_q  = '0;
					if (byte_mode) begin
						next_dq_out_q[DATA_W-1] = req_low_byte;
						next_dq_out_q[14:8]     = 7'h00;
						next_dq_oe_q[DATA_W-1]  = 1'b1;
					end
					if (req_kind == FBO_REQ_PROTECT) begin
						next_addr_q[BIT_A6] = 1'b0;
						next_addr_q[BIT_A1] = 1'b1;
						next_addr_q[BIT_A0] = 1'b0;
						next_hv             = 1'b1;
					end else if (req_kind == FBO_REQ_UNPROTECT) begin
						next_addr_q[BIT_A6] = 1'b1;
						next_addr_q[BIT_A1] = 1'b1;
						next_addr_q[BIT_A0] = 1'b0;
						next_hv             = 1'b1;
					end
					if (req_kind == FBO_REQ_RESET) begin
						next_rst_pin_n = 1'b0;
						next_ce_n      = 1'b1;
						next_hv        = 1'b0;
						next_dq_oe_q   = '0;
						tmr_load       = 1'b1;
						tmr_value      = CNT_W'(RESET_CYC - 1);
						next_state     = FBO_RST_LOW;
					end else begin
						next_ce_n  = 1'b0;
						next_state = FBO_SETUP;
					end
				end
			end
			FBO_SETUP: begin
				tmr_load = 1'b1;
				if (kind == FBO_REQ_READ) begin
					// gate low, strobe high, data pins released but for pin 15 in byte mode
					next_oe_n    = 1'b0;
					// byte mode keeps pin 15 driven as low address bit
					next_dq_oe_q = word_q ? 16'h0000 : 16'h8000;
					tmr_value    = CNT_W'(ACCESS_CYC - 1);
				end else begin
					// drive data, strobe low, gate high
					next_we_n = 1'b0;
					if (word_q) begin
						next_dq_oe_q = '1;
					end else begin
						next_dq_oe_q = 16'h80FF;
					end
					tmr_value = CNT_W'(WRITE_CYC - 1);
				end
				next_state = FBO_STROBE;
			end
			FBO_STROBE: begin
				if (tmr_done) begin
					if (kind == FBO_REQ_READ) begin
						next_rvalid_q = 1'b1;
						// byte reads use only the low eight pins
						next_rdata_q = word_q ? flash_dq_in
						             : {8'h00, flash_dq_in[7:0]};
					end
					next_oe_n    = 1'b1;
					next_we_n    = 1'b1;
					next_ce_n    = 1'b1;
					next_dq_oe_q = '0;
					tmr_load     = 1'b1;
					tmr_value    = CNT_W'(RECOVERY_CYC - 1);
					next_state   = FBO_RECOVER;
				end
			end
			FBO_RECOVER: begin
				if (tmr_done) begin
					next_hv      = temp_unprotect;
					next_ready_q = 1'b1;
					next_state   = FBO_IDLE;
				end
			end
			FBO_RST_LOW: begin
				if (tmr_done) begin
					// device returns to reading array on release
					next_rst_pin_n = 1'b1;
					tmr_load       = 1'b1;
					tmr_value      = CNT_W'(RESET_H_CYC - 1);
					next_state     = FBO_RST_WT;
				end
			end
			FBO_RST_WT: begin
				if (tmr_done) begin
					next_ready_q = 1'b1;
					next_state   = FBO_IDLE;
				end
			end
			default: begin
				next_state = FBO_IDLE;
			end
		endcase
	end

	// -------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state     <= FBO_IDLE;
			kind      <= FBO_REQ_READ;
			addr_q    <= '0;
			dq_out_q  <= '0;
			dq_oe_q   <= '0;
			ce_n      <= 1'b1;
			oe_n      <= 1'b1;
			we_n      <= 1'b1;
			rst_pin_n <= 1'b0; // device held in reset with the host
			hv        <= 1'b0;
			word_q    <= 1'b1;
			ready_q   <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			boot_q    <= 1'b0;
		end else begin
			state     <= next_state;
			kind      <= next_kind;
			addr_q    <= next_addr_q;
			dq_out_q  <= next_dq_out_q;
			dq_oe_q   <= next_dq_oe_q;
			ce_n      <= next_ce_n;
			oe_n      <= next_oe_n;
			we_n      <= next_we_n;
			rst_pin_n <= next_rst_pin_n;
			hv        <= next_hv;
			word_q    <= next_word_q;
			ready_q   <= next_ready_q;
			rvalid_q  <= next_rvalid_q;
			rdata_q   <= next_rdata_q;
			boot_q    <= next_boot_q;
		end
	end

	// -------------------------------------------------------------------
	// outputs straight from flip-flops
	// -------------------------------------------------------------------
	assign req_ready                = ready_q;
	assign rsp_valid                = rvalid_q;
	assign rsp_rdata                = rdata_q;
	assign rsp_boot_bank            = boot_q;
	assign flash_addr               = addr_q;
	assign flash_dq_out             = dq_out_q;
	assign flash_dq_oe              = dq_oe_q;
	assign flash_ce_n               = ce_n;
	assign flash_oe_n               = oe_n;
	assign flash_we_n               = we_n;
	assign flash_reset_n            = rst_pin_n;
	assign flash_high_voltage_level = hv;
	assign flash_word_mode          = word_q;

endmodule

// ---- sim/fbo_host_checker.sv ----
// Purpose: port checks on the flash bus controller
// Assumes: one clock, rst_n async active low
// Notes:   bound into every fbo_host
`timescale 1ns/1ps
module fbo_host_checker
	import fbo_pkg::*;
(
	// clock and reset
	input wire logic              clock,
	input wire logic              rst_n,
	// user side
	input wire logic              req_valid,
	input wire fbo_req_t          req_kind,
	input wire logic              req_ready,
	input wire logic              byte_mode,
	input wire logic              rsp_valid,
	input wire logic [DATA_W-1:0] rsp_rdata,
	// flash pins
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic [DATA_W-1:0] flash_dq_oe,
	input wire logic              flash_ce_n,
	input wire logic              flash_oe_n,
	input wire logic              flash_we_n,
	input wire logic              flash_reset_n,
	input wire logic              flash_high_voltage_level,
	input wire logic              flash_word_mode
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// request taken, high voltage strobe with A1 high and A0 low
	wire take = req_valid && req_ready;
	wire hv_wr = !flash_we_n && flash_high_voltage_level
		&& flash_addr[1:0] == 2'b10;

	read_levels_a: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n)
		else $error("gate low without read levels");
	write_levels_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
		else $error("strobe low without write levels");
	bus_contend_a: assert property (!flash_oe_n |->
		flash_dq_oe == (flash_word_mode ? 16'h0000 : 16'h8000))
		else $error("host drives while gate low");
	byte_pins_a: assert property (!flash_word_mode |-> flash_dq_oe[14:8] == 7'h00)
		else $error("pins 14..8 driven in byte mode");
	width_follow_a: assert property (take && req_kind != FBO_REQ_RESET
		|=> flash_word_mode == !$past(byte_mode)) else $error("width select wrong");
	reset_len_a: assert property ($fell(flash_reset_n)
		|-> !flash_reset_n [*5] ##1 flash_reset_n) else $error("reset pulse length");
	read_answer_a: assert property (take && req_kind == FBO_REQ_READ
		|-> ##4 rsp_valid) else $error("read answer late");
	protect_pins_a: assert property (take && req_kind == FBO_REQ_PROTECT
		|-> ##[1:6] hv_wr && !flash_addr[6]) else $error("protect cycle missing");
	unprot_pins_a: assert property (take && req_kind == FBO_REQ_UNPROTECT
		|-> ##[1:6] hv_wr && flash_addr[6]) else $error("unprotect cycle missing");
	resp_byte_a: assert property (rsp_valid && !flash_word_mode
		|-> rsp_rdata[15:8] == 8'h00) else $error("byte read upper not zero");
	// main scenarios
	cover property (take && req_kind == FBO_REQ_READ);
	cover property (take && req_kind == FBO_REQ_WRITE);
	cover property (hv_wr);
	cover property ($fell(flash_reset_n));
endmodule

bind fbo_host fbo_host_checker chk (.clock(clock), .rst_n(rst_n),
	.req_valid(req_valid), .req_kind(req_kind), .req_ready(req_ready),
	.byte_mode(byte_mode), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
	.flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe),
	.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
	.flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n),
	.flash_high_voltage_level(flash_high_voltage_level),
	.flash_word_mode(flash_word_mode));

// ---- sim/fbo_flash_model.sv ----
// Purpose: behavioural parallel flash on the controller pins
// Assumes: pins sampled on the controller clock
// Notes:   erased words read all ones; A-1 low selects low byte
`timescale 1ns/1ps
module fbo_flash_model
	import fbo_pkg::*;
(
	input  wire logic              clock,
	// flash pins
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] dq_out,
	input  wire logic [DATA_W-1:0] dq_oe,
	input  wire logic              ce_n,
	input  wire logic              oe_n,
	input  wire logic              we_n,
	input  wire logic              reset_n,
	input  wire logic              hv,
	input  wire logic              word_mode,
	output logic [DATA_W-1:0]      dq_in
);
	logic [DATA_W-1:0] mem [int];
	bit                prot [int];
	logic              tmp = 1'b0;
	logic [DATA_W-1:0] junk = 16'hA5C3;
	logic [DATA_W-1:0] w;
	logic [DATA_W-1:0] r;
	wire               low_a = dq_oe[15] & dq_out[15];

	function automatic logic [DATA_W-1:0] word_at(input int k);
		return mem.exists(k) ? mem[k] : 16'hFFFF;
	endfunction

	// write latch feeds array or protection, ignored in reset
	always @(posedge clock) begin
		junk <= ~junk;
		if (ce_n) tmp <= hv;
		if (reset_n && !ce_n && oe_n && !we_n) begin
			if (hv && addr[1:0] == 2'b10) prot[addr[18:12]] = !addr[6];
			else if (!(prot.exists(addr[18:12]) && prot[addr[18:12]]) || tmp) begin
				w = word_at(addr);
				if (word_mode) w = dq_out;
				else if (low_a) w[15:8] = dq_out[7:0];
				else w[7:0] = dq_out[7:0];
				mem[addr] = w;
			end
		end
	end

	// read drive, released pins show a changing pattern
	always @* begin
		r = word_at(addr);
		if (reset_n && !ce_n && !oe_n && we_n)
			dq_in = word_mode ? r : {junk[15:8], low_a ? r[15:8] : r[7:0]};
		else
			dq_in = junk;
	end
endmodule

// ---- sim/fbo_host_tb_top.sv ----
// Purpose: self-checking bench for the flash bus controller
// Assumes: inputs driven at falling edge
// Notes:   reference memory kept in associative arrays of the bench
`timescale 1ns/1ps
module fbo_host_tb_top;
	import fbo_pkg::*;
	logic              clock = 0, rst_n = 0, req_valid = 0, req_low_byte = 0;
	logic              byte_mode = 0, temp_unprotect = 0;
	fbo_req_t          req_kind = FBO_REQ_READ;
	logic [ADDR_W-1:0] req_addr = '0, flash_addr, a;
	logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, dq_out, dq_oe, dq_in, got;
	logic              req_ready, rsp_valid, rsp_boot_bank, ce_n, oe_n, we_n;
	logic              fl_rst_n, hv, word_mode, got_b, seen;
	int                mismatches = 0, check_count = 0;
	logic [DATA_W-1:0] ref_mem [int];
	bit                ref_prot [int];

	always #50 clock = ~clock;
	fbo_host dut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
		.req_kind(req_kind), .req_addr(req_addr), .req_low_byte(req_low_byte),
		.req_wdata(req_wdata), .byte_mode(byte_mode),
		.temp_unprotect(temp_unprotect), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_boot_bank(rsp_boot_bank), .flash_addr(flash_addr),
		.flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in),
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.flash_reset_n(fl_rst_n), .flash_high_voltage_level(hv),
		.flash_word_mode(word_mode));
	fbo_flash_model flash (.clock(clock), .addr(flash_addr), .dq_out(dq_out),
		.dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.reset_n(fl_rst_n), .hv(hv), .word_mode(word_mode), .dq_in(dq_in));

	// catch the one-cycle answer
	always @(posedge clock) if (rsp_valid === 1'b1) begin
		got <= rsp_rdata;
		got_b <= rsp_boot_bank;
		seen <= 1'b1;
	end

	task automatic results;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [DATA_W-1:0] e, g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [DATA_W-1:0] ref_word(input int k);
		return ref_mem.exists(k) ? ref_mem[k] : 16'hFFFF;
	endfunction
	// one request, held until taken, then wait for idle
	task automatic req(input fbo_req_t k, input logic [ADDR_W-1:0] ad,
		input logic lb, input logic [DATA_W-1:0] wd);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 40) begin @(negedge clock); n++; end
		seen = 0; req_kind = k; req_addr = ad; req_low_byte = lb;
		req_wdata = wd; req_valid = 1;
		@(negedge clock);
		req_valid = 0;
		n = 0;
		while (req_ready !== 1'b1 && n < 40) begin @(negedge clock); n++; end
		if (n == 40) chk("ready", 16'h0001, 16'h0000);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] ad, input logic lb,
		input logic [DATA_W-1:0] wd);
		int k;
		logic [DATA_W-1:0] m;
		req(FBO_REQ_WRITE, ad, lb, wd);
		k = ad[18:12];
		m = ref_word(ad);
		if (!byte_mode) m = wd;
		else if (lb) m[15:8] = wd[7:0];
		else m[7:0] = wd[7:0];
		if (!(ref_prot.exists(k) && ref_prot[k]) || temp_unprotect) ref_mem[ad] = m;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] ad, input logic lb);
		logic [DATA_W-1:0] m;
		req(FBO_REQ_READ, ad, lb, 16'h0000);
		m = ref_word(ad);
		if (byte_mode) m = {8'h00, lb ? m[15:8] : m[7:0]};
		chk("rsp_valid", 16'h0001, {15'h0, seen});
		chk("rsp_rdata", m, got);
		chk("boot_bank", {15'h0, ad[18:15] == 4'hF}, {15'h0, got_b});
	endtask

	// watchdog
	initial begin
		#1000000;
		mismatches++;
		results;
	end

	// main sequence
	initial begin
		void'($urandom(32'h2075));
		repeat (10) @(negedge clock);
		rst_n = 1;
		rd(19'h00123, 0);
		for (int i = 0; i < 12; i++) begin
			a = 19'($urandom);
			wr(a, 0, 16'($urandom));
			rd(a, 0);
		end
		byte_mode = 1;
		for (int i = 0; i < 4; i++) begin
			a = 19'($urandom);
			wr(a, i[0], 16'($urandom));
			rd(a, i[0]);
			rd(a, !i[0]);
		end
		byte_mode = 0;
		rd(a, 0);
		a = 19'h7F001;
		req(FBO_REQ_PROTECT, a, 0, 16'h0000);
		ref_prot[a[18:12]] = 1;
		wr(a, 0, 16'h1234);
		rd(a, 0);
		temp_unprotect = 1;
		repeat (3) @(negedge clock);
		wr(a, 0, 16'h5A5A);
		rd(a, 0);
		temp_unprotect = 0;
		repeat (3) @(negedge clock);
		req(FBO_REQ_UNPROTECT, a, 0, 16'h0000);
		ref_prot[a[18:12]] = 0;
		wr(a, 0, 16'hC33C);
		rd(a, 0);
		req(FBO_REQ_RESET, a, 0, 16'h0000);
		rd(a, 0);
		rst_n = 0;
		repeat (3) @(negedge clock);
		rst_n = 1;
		rd(a, 0);
		results;
	end
endmodule
